// ==== hdl/debug_vector_select.sv ====
// Breakpoint trigger sequencing and debug exception vector choice.
// Assumes hits and the interrupt sample point come from logic on clk.
`timescale 1ns/1ps
module debug_vector_select
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Trigger setup and hits
  input wire logic armed,
  input wire logic two_level,
  input wire logic pc_hit,
  input wire logic bus_hit,
  input wire logic int_sample,
  input wire logic [31:0] next_pc,
  // Exception request
  output logic stall_issue,
  output logic exc_req,
  output logic [7:0] exc_vector,
  output logic [11:0] exc_offset,
  output logic [31:0] stacked_pc,
  // Breakpoint state report
  output logic bp_change,
  output logic [1:0] bp_idx
);

  trace_debug_pkg::vec_state_t st;
  trace_debug_pkg::vec_state_t next_st;
  logic final_stage;
  logic pc_final;
  logic bus_final;
  logic take_bus;

  // Only a hit in the last trigger level raises an exception, even in the cycle that armed drops
  // R5: final event decides
  assign final_stage = (st.trig == trace_debug_pkg::TRIG_WAIT2) ||
    (st.trig == trace_debug_pkg::TRIG_WAIT1 && !two_level);
  // R3: stall before execute
  assign pc_final = final_stage & pc_hit;
  assign bus_final = final_stage & bus_hit & ~pc_hit;
  // R4: pending until sampled
  assign take_bus = st.pending & int_sample & ~pc_final;

  // Trigger sequencer, pending flag and exception choice
  always_comb
  begin
    next_st = st;
    next_st.exc_req = 1'b0;
    next_st.change = 1'b0;
    case (st.trig)
      trace_debug_pkg::TRIG_IDLE:
      begin
        if (armed)
        begin
          next_st.trig = trace_debug_pkg::TRIG_WAIT1;
          next_st.change = 1'b1;
          next_st.state_idx = trace_debug_pkg::BP_WAIT1;
        end
      end
      trace_debug_pkg::TRIG_WAIT1:
      begin
        if (!armed)
          next_st.trig = trace_debug_pkg::TRIG_IDLE;
        else if (pc_hit || bus_hit)
        begin
          next_st.change = 1'b1;
          next_st.trig = two_level ? trace_debug_pkg::TRIG_WAIT2 :
            trace_debug_pkg::TRIG_DONE;
          next_st.state_idx = two_level ? trace_debug_pkg::BP_WAIT2 :
            trace_debug_pkg::BP_TRIG1;
        end
      end
      trace_debug_pkg::TRIG_WAIT2:
      begin
        if (!armed)
          next_st.trig = trace_debug_pkg::TRIG_IDLE;
        else if (pc_hit || bus_hit)
        begin
          next_st.trig = trace_debug_pkg::TRIG_DONE;
          next_st.change = 1'b1;
          next_st.state_idx = trace_debug_pkg::BP_TRIG2;
        end
      end
      trace_debug_pkg::TRIG_DONE:
      begin
        if (!armed)
          next_st.trig = trace_debug_pkg::TRIG_IDLE;
      end
      default:
        next_st.trig = trace_debug_pkg::TRIG_IDLE;
    endcase
    // A new hit beats the clear of an older one
    next_st.pending = (st.pending & ~take_bus) | bus_final;
    // R18: stack next address
    if (pc_final)
    begin
      // R2: PC vector 13
      next_st.exc_req = 1'b1;
      next_st.vector = trace_debug_pkg::VEC_PC;
      next_st.offset = trace_debug_pkg::OFF_PC;
      next_st.stacked_pc = next_pc;
    end
    else if (take_bus)
    begin
      // R1: other vector 12
      next_st.exc_req = 1'b1;
      next_st.vector = trace_debug_pkg::VEC_NON_PC;
      next_st.offset = trace_debug_pkg::OFF_NON_PC;
      next_st.stacked_pc = next_pc;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk)
  begin
    if (!rstn)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign stall_issue = pc_final;
  assign exc_req = st.exc_req;
  assign exc_vector = st.vector;
  assign exc_offset = st.offset;
  assign stacked_pc = st.stacked_pc;
  assign bp_change = st.change;
  assign bp_idx = st.state_idx;

  // R2: PC vector 13
  a_pc_vector: assert property ( // R2
    @(posedge clk) disable iff (!rstn)
    pc_final && ce |-> stall_issue ##1
    (exc_req && exc_vector == 8'h0D && exc_offset == 12'h034))
    else $error("PC breakpoint did not take vector 13");

  // R1: other vector 12
  a_nonpc_vector: assert property ( // R1
    @(posedge clk) disable iff (!rstn)
    ce && st.pending && int_sample && !pc_final |=>
    exc_req && exc_vector == 8'h0C && exc_offset == 12'h030)
    else $error("bus breakpoint did not take vector 12");

  // R4: bus hit deferred
  a_bus_deferred: assert property ( // R4
    @(posedge clk) disable iff (!rstn)
    ce && bus_final && !st.pending |=> !exc_req && st.pending)
    else $error("bus breakpoint taken before sampling");

  // R18: stacked next address
  a_stacked_next: assert property ( // R18
    @(posedge clk) disable iff (!rstn)
    ce && (pc_final || take_bus) |=> stacked_pc == $past(next_pc))
    else $error("stacked address is not the next instruction");

  // R5: first level silent
  a_two_level: assert property ( // R5
    @(posedge clk) disable iff (!rstn)
    ce && armed && two_level && (pc_hit || bus_hit) &&
    st.trig == trace_debug_pkg::TRIG_WAIT1 |=>
    !exc_req && !st.pending && st.trig == trace_debug_pkg::TRIG_WAIT2)
    else $error("first trigger level raised an exception");

endmodule

// ==== hdl/trace_debug_port.sv ====
// Trace port: turns core status events into a nibble stream on an 8-bit
// bus at half the core rate, and hosts the debug vector selector.
// Assumes requests and breakpoint hits come from logic on clk.
// Contract
// R1: Non-PC breakpoint interrupt uses vector 12.
// R2: PC breakpoint interrupt uses vector 13.
// R3: PC breakpoint taken before instruction executes.
// R4: Other breakpoints pend until interrupt sampling.
// R5: Final trigger event picks the vector.
// R6: Trace bus updates at half core rate.
// R7: Status and data share one byte bus.
// R8: Marker and its data stay contiguous.
// R9: Idle code may fill other slots.
// R10: Nibbles may sit in either half.
// R11: Breakpoint state change: marker, then state.
// R12: State nibbles 2, 4, A, C meanings.
// R13: Marker twice means emulator mode entry.
// R14: Codes C to F held several slots.
// R15: Execution codes 0 to 7 encodings.
// R16: Codes 8 to B announce 1-4 bytes.
// R17: C exception, E stopped, F halted.
// R18: Debug vectors stack next instruction address.
// R19: Idle code on both nibbles after reset.
// R20: Data nibbles go out least significant first.
`timescale 1ns/1ps
module trace_debug_port
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Trace request from the core
  input wire logic req_valid,
  input wire trace_debug_pkg::req_kind_t req_kind,
  input wire logic [3:0] req_code,
  input wire logic [1:0] req_count,
  input wire logic [31:0] req_data,
  output logic req_ready,
  // Breakpoint trigger inputs
  input wire logic bkpt_armed,
  input wire logic bkpt_two_level,
  input wire logic pc_hit,
  input wire logic bus_hit,
  input wire logic int_sample,
  input wire logic [31:0] next_pc,
  // Debug exception to the core
  output logic stall_issue,
  output logic exc_req,
  output logic [7:0] exc_vector,
  output logic [11:0] exc_offset,
  output logic [31:0] stacked_pc,
  // Trace pins
  output logic [7:0] trace_status_data_bus,
  output logic trace_half_rate_clock
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int DEPTH = trace_debug_pkg::QUEUE_DEPTH;

  trace_debug_pkg::trace_state_t st;
  trace_debug_pkg::trace_state_t next_st;
  trace_debug_pkg::req_kind_t sel_kind;
  logic bp_change;
  logic [1:0] bp_idx_new;
  logic room;
  logic take;
  logic [3:0] status_code;
  logic [3:0] data_code;
  logic [3:0] data_len;
  logic [3:0] bp_code;
  logic [3:0] seq_len;
  logic [3:0] pop;
  logic [3:0] base;
  logic [DEPTH+1:0][3:0] nib_pad;
  wire logic [DEPTH-1:0][3:0] seq_nib;
  wire logic [DEPTH-1:0][3:0] q_next;

  // ****************************************
  // Debug vector selection
  // ****************************************
  debug_vector_select u_vector
  (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .armed(bkpt_armed),
    .two_level(bkpt_two_level),
    .pc_hit(pc_hit),
    .bus_hit(bus_hit),
    .int_sample(int_sample),
    .next_pc(next_pc),
    .stall_issue(stall_issue),
    .exc_req(exc_req),
    .exc_vector(exc_vector),
    .exc_offset(exc_offset),
    .stacked_pc(stacked_pc),
    .bp_change(bp_change),
    .bp_idx(bp_idx_new)
  );

  // ****************************************
  // Sequence builder
  // ****************************************

  // Pending breakpoint reports go ahead of core requests
  assign sel_kind = st.bp_pend ? trace_debug_pkg::KIND_BPSTATE : req_kind;
  // Append only while at most one nibble waits, so a whole sequence fits
  assign room = st.count <= trace_debug_pkg::APPEND_MAX;
  assign take = room & (st.bp_pend | req_valid);
  assign req_ready = ce & room & ~st.bp_pend;

  // R15: execution codes pass
  // R17: C, E, F pass
  assign status_code = ((req_code >= trace_debug_pkg::CODE_DATA_BASE &&
    req_code < trace_debug_pkg::CODE_HOLD_MIN) ||
    req_code == trace_debug_pkg::CODE_MARK) ?
    trace_debug_pkg::CODE_IDLE : req_code;

  // R16: byte count code
  assign data_code = trace_debug_pkg::CODE_DATA_BASE + {2'h0, req_count};
  assign data_len = trace_debug_pkg::DATA_LEN_BASE + {1'b0, req_count, 1'b0};

  // R12: state value map
  assign bp_code = (st.bp_idx == trace_debug_pkg::BP_WAIT1) ?
    trace_debug_pkg::BPC_WAIT1 :
    (st.bp_idx == trace_debug_pkg::BP_TRIG1) ? trace_debug_pkg::BPC_TRIG1 :
    (st.bp_idx == trace_debug_pkg::BP_WAIT2) ? trace_debug_pkg::BPC_WAIT2 :
    trace_debug_pkg::BPC_TRIG2;

  // Sequence length per kind
  // R14: hold long codes
  assign seq_len = (sel_kind == trace_debug_pkg::KIND_DATA) ? data_len :
    (sel_kind == trace_debug_pkg::KIND_BPSTATE) ? trace_debug_pkg::BP_LEN :
    (sel_kind == trace_debug_pkg::KIND_EMUL) ? trace_debug_pkg::HOLD_NIBBLES :
    (status_code >= trace_debug_pkg::CODE_HOLD_MIN) ?
    trace_debug_pkg::HOLD_NIBBLES : trace_debug_pkg::SINGLE_LEN;

  // Two nibbles leave at every slot end, fewer when the queue is short
  assign pop = !st.phase ? 4'h0 :
    (st.count >= trace_debug_pkg::SLOT_NIBBLES) ?
    trace_debug_pkg::SLOT_NIBBLES : st.count;
  assign base = st.count - pop;
  assign nib_pad = {{trace_debug_pkg::CODE_IDLE, trace_debug_pkg::CODE_IDLE},
    st.nib};

  // ****************************************
  // Per-entry sequence and queue update
  // ****************************************
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    logic [3:0] data_nib;
    logic [3:0] kind_nib;
    logic [3:0] shifted;
    logic [3:0] src_idx;
    // R20: low nibble first
    if (i >= 1 && i <= 8)
    begin : g_data
      assign data_nib = req_data[4*(i-1) +: 4];
    end
    else
    begin : g_nodata
      assign data_nib = trace_debug_pkg::CODE_IDLE;
    end
    // R11: single marker, state
    // R13: marker repeated
    assign kind_nib = (sel_kind == trace_debug_pkg::KIND_DATA) ?
      ((i == 0) ? data_code : data_nib) :
      (sel_kind == trace_debug_pkg::KIND_BPSTATE) ?
      ((i == 0) ? trace_debug_pkg::CODE_MARK : bp_code) :
      (sel_kind == trace_debug_pkg::KIND_EMUL) ?
      trace_debug_pkg::CODE_MARK : status_code;
    assign seq_nib[i] = (4'(i) < seq_len) ? kind_nib :
      trace_debug_pkg::CODE_IDLE;
    assign shifted = (pop == trace_debug_pkg::SLOT_NIBBLES) ? nib_pad[i+2] :
      (pop == 4'h0) ? nib_pad[i] : nib_pad[i+1];
    // R8: contiguous append
    // R10: any nibble half
    assign src_idx = 4'(i) - base;
    assign q_next[i] = (take && 4'(i) >= base && src_idx < seq_len) ?
      seq_nib[src_idx] : shifted;
  end

  // ****************************************
  // Slot timing and state update
  // ****************************************

  // Divide by two; the bus moves as the trace clock falls, so a receiver
  // sampling on the rising edge sees half a slot of setup and hold
  always_comb
  begin
    next_st = st;
    // R6: half rate slots
    next_st.phase = ~st.phase;
    next_st.nib = q_next;
    next_st.count = base + (take ? seq_len : 4'h0);
    // R7: shared byte bus
    // R9: idle pad
    if (st.phase)
    begin
      next_st.bus[7:4] = (st.count > 4'h1) ? st.nib[1] :
        trace_debug_pkg::CODE_IDLE;
      next_st.bus[3:0] = (st.count > 4'h0) ? st.nib[0] :
        trace_debug_pkg::CODE_IDLE;
    end
    // A report that arrives while the previous one leaves is kept
    next_st.bp_pend = (st.bp_pend & ~take) | bp_change;
    if (bp_change)
      next_st.bp_idx = bp_idx_new;
  end

  // R19: idle from reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign trace_status_data_bus = st.bus;
  assign trace_half_rate_clock = st.phase;

  // ****************************************
  // Checks
  // ****************************************

  // R19: idle after reset
  a_idle_reset: assert property ( // R19
    @(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> trace_status_data_bus == 8'h00)
    else $error("trace bus not idle after reset");

  // R6: bus moves on fall
  a_bus_on_fall: assert property ( // R6
    @(posedge clk) disable iff (!rstn)
    $changed(trace_status_data_bus) |->
    !trace_half_rate_clock && $past(trace_half_rate_clock))
    else $error("trace bus changed away from a slot edge");

  // R11: marker then state
  a_marker_pair: assert property ( // R11
    @(posedge clk) disable iff (!rstn)
    take && st.bp_pend |-> seq_len == 4'h2 && seq_nib[0] == 4'hD &&
    seq_nib[1] inside {4'h2, 4'h4, 4'hA, 4'hC})
    else $error("breakpoint report is not marker plus state");

  // R13: emulator entry pair
  a_emul_double: assert property ( // R13
    @(posedge clk) disable iff (!rstn)
    take && !st.bp_pend && req_kind == trace_debug_pkg::KIND_EMUL |->
    seq_nib[0] == 4'hD && seq_nib[1] == 4'hD && seq_len == 4'h4)
    else $error("emulator entry is not a repeated marker");

  // R16: data count code
  a_data_count: assert property ( // R16
    @(posedge clk) disable iff (!rstn)
    take && !st.bp_pend && req_kind == trace_debug_pkg::KIND_DATA |->
    seq_nib[0] == 4'h8 + {2'h0, req_count} &&
    seq_len == 4'h3 + {1'b0, req_count, 1'b0} && seq_nib[1] == req_data[3:0])
    else $error("data transfer code or length wrong");

  // R14: long codes held
  a_hold_long: assert property ( // R14
    @(posedge clk) disable iff (!rstn)
    ce && take && !st.bp_pend && req_kind == trace_debug_pkg::KIND_STATUS &&
    status_code >= 4'hC |=> st.count >= 4'h4)
    else $error("long status code not held");

  // R9: idle fills gap
  a_pad_idle: assert property ( // R9
    @(posedge clk) disable iff (!rstn)
    ce && st.phase && st.count == 4'h1 |=>
    trace_status_data_bus[7:4] == 4'h0)
    else $error("unused nibble is not idle");

endmodule

// ==== inc/trace_debug_pkg.sv ====
// Constants and state types shared by the trace port and the vector select.
// Assumes one core clock; every user writes trace_debug_pkg::name.
package trace_debug_pkg;

  // ****************************************
  // Debug exception vectors
  // ****************************************
  localparam logic [7:0] VEC_NON_PC = 8'h0C;
  localparam logic [7:0] VEC_PC = 8'h0D;
  localparam logic [11:0] OFF_NON_PC = 12'h030;
  localparam logic [11:0] OFF_PC = 12'h034;

  // ****************************************
  // Trace status codes
  // ****************************************
  localparam logic [3:0] CODE_IDLE = 4'h0;
  localparam logic [3:0] CODE_ONE = 4'h1;
  localparam logic [3:0] CODE_TWO = 4'h2;
  localparam logic [3:0] CODE_USER = 4'h3;
  localparam logic [3:0] CODE_PULSE = 4'h4;
  localparam logic [3:0] CODE_BRANCH = 4'h5;
  localparam logic [3:0] CODE_INSN_BRANCH = 4'h6;
  localparam logic [3:0] CODE_RETURN = 4'h7;
  localparam logic [3:0] CODE_DATA_BASE = 4'h8;
  localparam logic [3:0] CODE_HOLD_MIN = 4'hC;
  localparam logic [3:0] CODE_EXCEPTION = 4'hC;
  localparam logic [3:0] CODE_MARK = 4'hD;
  localparam logic [3:0] CODE_STOPPED = 4'hE;
  localparam logic [3:0] CODE_HALTED = 4'hF;

  // Breakpoint state values sent after the marker
  localparam logic [3:0] BPC_WAIT1 = 4'h2;
  localparam logic [3:0] BPC_TRIG1 = 4'h4;
  localparam logic [3:0] BPC_WAIT2 = 4'hA;
  localparam logic [3:0] BPC_TRIG2 = 4'hC;
  localparam logic [1:0] BP_WAIT1 = 2'h0;
  localparam logic [1:0] BP_TRIG1 = 2'h1;
  localparam logic [1:0] BP_WAIT2 = 2'h2;
  localparam logic [1:0] BP_TRIG2 = 2'h3;

  // ****************************************
  // Nibble queue sizing and sequence lengths
  // ****************************************
  localparam int QUEUE_DEPTH = 12;
  localparam logic [3:0] HOLD_NIBBLES = 4'h4;
  localparam logic [3:0] SINGLE_LEN = 4'h1;
  localparam logic [3:0] BP_LEN = 4'h2;
  localparam logic [3:0] DATA_LEN_BASE = 4'h3;
  localparam logic [3:0] SLOT_NIBBLES = 4'h2;
  localparam logic [3:0] APPEND_MAX = 4'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0]
  {
    KIND_STATUS = 2'h0,
    KIND_DATA = 2'h1,
    KIND_BPSTATE = 2'h2,
    KIND_EMUL = 2'h3
  } req_kind_t;

  typedef enum logic [1:0]
  {
    TRIG_IDLE = 2'h0,
    TRIG_WAIT1 = 2'h1,
    TRIG_WAIT2 = 2'h3,
    TRIG_DONE = 2'h2
  } trig_state_t;

  typedef struct packed {
    logic phase;
    logic [7:0] bus;
    logic [3:0] count;
    logic [QUEUE_DEPTH-1:0][3:0] nib;
    logic bp_pend;
    logic [1:0] bp_idx;
  } trace_state_t;

  typedef struct packed {
    trig_state_t trig;
    logic pending;
    logic exc_req;
    logic [7:0] vector;
    logic [11:0] offset;
    logic [31:0] stacked_pc;
    logic change;
    logic [1:0] state_idx;
  } vec_state_t;

endpackage

// ==== tb/trace_capture_model.sv ====
// Trace capture model: stands in for the external trace receiver.
// Assumes it sees the trace pins directly and runs on the core clock.
`timescale 1ns/1ps
module trace_capture_model
(
  // Core clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Trace pins
  input wire logic [7:0] trace_status_data_bus,
  input wire logic trace_half_rate_clock,
  // Captured trace byte, valid for one cycle
  output logic cap_valid,
  output logic [7:0] cap_byte
);
  logic tclk_d;

  // sample on trace rise
  // The bus only moves as the trace clock falls, so reading it once the
  // rise is seen gives a settled byte; reset parks the edge detector high
  // byte passed whole
  // The bench splits it, low nibble first, with no alignment assumed
  always_ff @(posedge clk)
  begin
    tclk_d <= rstn ? trace_half_rate_clock : 1'b1;
    cap_valid <= rstn && trace_half_rate_clock && !tclk_d;
    cap_byte <= trace_status_data_bus;
  end
endmodule

// ==== tb/trace_debug_port_tb_top.sv ====
// Bench for the trace port: drives core requests and breakpoint hits,
// queues the expected nibbles and exceptions, compares what comes out.
// Assumes the capture model hands over one trace byte per trace slot.
`timescale 1ns/1ps
module trace_debug_port_tb_top;
  // ****************************************
  // Signals and expectation queues
  // ****************************************
  typedef struct packed {logic [3:0] nib; logic cont;} exp_nib_t;
  typedef struct packed
  {
    logic [7:0] vec;
    logic [11:0] off;
    logic [31:0] pc;
    logic [31:0] at;
  } exp_exc_t;
  logic clk, rstn, ce, req_valid, req_ready, must_follow;
  trace_debug_pkg::req_kind_t req_kind;
  logic [3:0] req_code;
  logic [1:0] req_count;
  logic [31:0] req_data, next_pc, stacked_pc, seed;
  logic [31:0] cyc = 32'h0000_0000;
  logic bkpt_armed, bkpt_two_level, pc_hit, bus_hit, int_sample;
  logic stall_issue, exc_req, cap_valid, trace_half_rate_clock;
  logic p_rst, p_ce, p_tclk;
  logic [7:0] exc_vector, cap_byte, trace_status_data_bus, p_bus;
  logic [11:0] exc_offset;
  int n_errors, num_checks;
  exp_nib_t nq[$];
  exp_exc_t eq[$];

  trace_debug_port dut
  (
    .clk(clk), .rstn(rstn), .ce(ce),
    .req_valid(req_valid), .req_kind(req_kind), .req_code(req_code),
    .req_count(req_count), .req_data(req_data), .req_ready(req_ready),
    .bkpt_armed(bkpt_armed), .bkpt_two_level(bkpt_two_level),
    .pc_hit(pc_hit), .bus_hit(bus_hit), .int_sample(int_sample),
    .next_pc(next_pc), .stall_issue(stall_issue), .exc_req(exc_req),
    .exc_vector(exc_vector), .exc_offset(exc_offset),
    .stacked_pc(stacked_pc),
    .trace_status_data_bus(trace_status_data_bus),
    .trace_half_rate_clock(trace_half_rate_clock)
  );

  trace_capture_model receiver
  (
    .clk(clk), .rstn(rstn),
    .trace_status_data_bus(trace_status_data_bus),
    .trace_half_rate_clock(trace_half_rate_clock),
    .cap_valid(cap_valid), .cap_byte(cap_byte)
  );

  // 200 MHz core clock and a cycle count for exception timing
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic push(input logic [3:0] n, input logic c);
    nq.push_back('{nib: n, cont: c});
  endtask

  task automatic push_hold(input logic [3:0] n);
    for (int i = 1; i <= trace_debug_pkg::HOLD_NIBBLES; i++)
      push(n, i < trace_debug_pkg::HOLD_NIBBLES);
  endtask

  // Holds the request until it is taken, then notes its nibbles; valid
  // stays up so a following call can go back to back
  task automatic send_req(input trace_debug_pkg::req_kind_t k,
    input logic [3:0] code, input logic [1:0] cnt, input logic [31:0] d);
    int w;
    w = 0;
    req_valid <= 1'b1;
    req_kind <= k;
    req_code <= code;
    req_count <= cnt;
    req_data <= d;
    do
    begin
      @(posedge clk);
      w++;
    end
    while (!req_ready && w < 100);
    check("req_ready", w < 100, 1'b1);
    if (k == trace_debug_pkg::KIND_DATA)
    begin
      push(trace_debug_pkg::CODE_DATA_BASE + 4'(cnt), 1'b1);
      for (int i = 0; i < 2 * (cnt + 1); i++)
        push(d[4 * i +: 4], i < 2 * cnt + 1);
    end
    else if (k == trace_debug_pkg::KIND_EMUL)
      push_hold(trace_debug_pkg::CODE_MARK);
    else if (code >= trace_debug_pkg::CODE_HOLD_MIN
      && code != trace_debug_pkg::CODE_MARK)
      push_hold(code);
    else if (code < trace_debug_pkg::CODE_DATA_BASE && code != 4'h0)
      push(code, 1'b0);
  endtask

  task automatic idle_req;
    req_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic drain;
    int w;
    w = 0;
    while ((nq.size() != 0 || eq.size() != 0) && w < 300)
    begin
      @(posedge clk);
      w++;
    end
    check("queues drained", nq.size() + eq.size(), 0);
    step(8);
  endtask

  // arm reports the first wait state
  task automatic arm(input logic two);
    bkpt_armed <= 1'b0;
    step(1);
    bkpt_two_level <= two;
    bkpt_armed <= 1'b1;
    push(trace_debug_pkg::CODE_MARK, 1'b1);
    push(trace_debug_pkg::BPC_WAIT1, 1'b0);
    step(3);
  endtask

  // One-cycle hit; a final PC hit must stall issue and trap on vector 13
  task automatic pulse_hit(input logic pc, input logic [3:0] st,
    input logic fin);
    seed = lfsr(seed);
    next_pc <= seed;
    if (pc)
      pc_hit <= 1'b1;
    else
      bus_hit <= 1'b1;
    push(trace_debug_pkg::CODE_MARK, 1'b1);
    push(st, 1'b0);
    if (pc && fin)
      eq.push_back('{trace_debug_pkg::VEC_PC, trace_debug_pkg::OFF_PC,
        seed, cyc + 2});
    @(negedge clk);
    check("stall_issue", stall_issue, pc && fin);
    @(posedge clk);
    if (pc)
      pc_hit <= 1'b0;
    else
      bus_hit <= 1'b0;
  endtask

  task automatic take_int;
    seed = lfsr(seed);
    next_pc <= seed;
    int_sample <= 1'b1;
    eq.push_back('{trace_debug_pkg::VEC_NON_PC,
      trace_debug_pkg::OFF_NON_PC, seed, cyc + 2});
    @(posedge clk);
    int_sample <= 1'b0;
  endtask

  // ****************************************
  // Output monitor
  // ****************************************
  // Idle nibbles are skipped only between sequences, never inside one
  task automatic take_nib(input logic [3:0] n);
    exp_nib_t e;
    if (!must_follow && n == 4'h0)
      return;
    if (nq.size() == 0)
    begin
      check("unexpected nibble", n, 4'h0);
      return;
    end
    e = nq.pop_front();
    check("trace nibble", n, e.nib);
    must_follow = e.cont;
  endtask

  always @(posedge clk)
  begin
    exp_exc_t ex;
    if (cap_valid)
    begin
      take_nib(cap_byte[3:0]);
      take_nib(cap_byte[7:4]);
    end
    if (exc_req === 1'b1 && eq.size() == 0)
      check("exc_req", 1'b1, 1'b0);
    else if (exc_req === 1'b1)
    begin
      ex = eq.pop_front();
      check("exc_vector", exc_vector, ex.vec);
      check("exc_offset", exc_offset, ex.off);
      check("stacked_pc", stacked_pc, ex.pc);
      check("exc cycle", cyc, ex.at);
    end
    // A frozen enable must freeze the trace clock as well
    if (p_rst)
      check("trace clock", trace_half_rate_clock,
        p_ce ? !p_tclk : p_tclk);
    if (p_rst && trace_status_data_bus !== p_bus)
      check("bus change", {p_tclk, trace_half_rate_clock}, 2'b10);
    p_rst = rstn;
    p_ce = ce;
    p_tclk = trace_half_rate_clock;
    p_bus = trace_status_data_bus;
  end

  // Hang guard, well beyond the few hundred cycles the run needs
  initial
  begin
    #100000;
    check("watchdog", 1'b1, 1'b0);
    complete_run;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rstn, req_valid, bkpt_armed, bkpt_two_level} = 4'h0;
    {pc_hit, bus_hit, int_sample, must_follow, p_rst} = 5'h00;
    {req_code, req_count, req_data, next_pc} = '0;
    req_kind = trace_debug_pkg::KIND_STATUS;
    ce = 1'b1;
    seed = 32'h7b3d_0d5c;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("idle bus", trace_status_data_bus, 8'h00);
    @(posedge clk);
    // Status codes 1 to F back to back; 8..B and D alone send nothing
    for (int c = 1; c < 16; c++)
      send_req(trace_debug_pkg::KIND_STATUS, 4'(c), 2'h0, 32'h0);
    // Every data length with random payload, mixed with random codes
    for (int n = 0; n < 8; n++)
    begin
      seed = lfsr(seed);
      send_req(trace_debug_pkg::KIND_DATA, 4'h0, 2'(n), seed);
      send_req(trace_debug_pkg::KIND_STATUS, seed[7:4], 2'h0, 32'h0);
    end
    send_req(trace_debug_pkg::KIND_EMUL, 4'h0, 2'h0, 32'h0);
    seed = lfsr(seed);
    send_req(trace_debug_pkg::KIND_DATA, 4'h0, 2'h3, seed);
    idle_req;
    // Stall the clock enable at random while four bytes drain
    repeat (40)
    begin
      seed = lfsr(seed);
      ce <= seed[0];
      @(posedge clk);
    end
    ce <= 1'b1;
    drain;
    // Hits and sampling while disarmed must do nothing
    {pc_hit, bus_hit, int_sample} <= 3'h7;
    step(1);
    {pc_hit, bus_hit, int_sample} <= 3'h0;
    drain;
    // one-level PC, one-level bus, then two-level bus-then-PC and PC-then-bus triggers
    arm(1'b0);
    pulse_hit(1'b1, trace_debug_pkg::BPC_TRIG1, 1'b1);
    drain;
    arm(1'b0);
    pulse_hit(1'b0, trace_debug_pkg::BPC_TRIG1, 1'b0);
    step(2);
    take_int;
    drain;
    arm(1'b1);
    pulse_hit(1'b0, trace_debug_pkg::BPC_WAIT2, 1'b0);
    step(3);
    pulse_hit(1'b1, trace_debug_pkg::BPC_TRIG2, 1'b1);
    drain;
    arm(1'b1);
    pulse_hit(1'b1, trace_debug_pkg::BPC_WAIT2, 1'b0);
    step(3);
    pulse_hit(1'b0, trace_debug_pkg::BPC_TRIG2, 1'b0);
    step(1);
    take_int;
    drain;
    // PC hit beats a bus hit in the same cycle; nothing is left pending
    arm(1'b0);
    bus_hit <= 1'b1;
    pulse_hit(1'b1, trace_debug_pkg::BPC_TRIG1, 1'b1);
    {bus_hit, int_sample} <= 2'h1;
    step(1);
    int_sample <= 1'b0;
    drain;
    complete_run;
  end
endmodule
